// File: shared/gtw_consts.svh
// register map, field positions, reset values and timing counts
`ifndef GTW_CONSTS_SVH
`define GTW_CONSTS_SVH

`define ADDR_GENERAL_TIMER_A_COUNT   32'h5002_0000
`define ADDR_GENERAL_TIMER_A_CONTROL 32'h5002_0004
`define ADDR_GENERAL_TIMER_B_COUNT   32'h5002_0008
`define ADDR_GENERAL_TIMER_B_CONTROL 32'h5002_000C
`define ADDR_GENERAL_TIMER_C_COUNT   32'h5002_0010
`define ADDR_GENERAL_TIMER_C_CONTROL 32'h5002_0014
`define ADDR_WDT_SETUP      32'h5002_0018
`define ADDR_WDT_KEY        32'h5002_001C
`define ADDR_TIMER_IRQ_EN   32'h5002_0060
`define TIMER_STRIDE        32'h0000_0008

`define TIMER_RUN_BIT       0
`define WDT_ENABLE_BIT      0
`define WDT_EXPIRY_RESET_ENABLE_BIT       1
`define WDT_FLAG_BIT        2
`define WDT_SEL_LSB         3
`define WDT_SEL_MSB         4

`define TIMER_COUNT_RESET   32'h0000_0000
`define WDT_SEL_RESET       2'h0
`define WDT_KEY_RESET       32'h0000_0000
`define WDT_KEY_FIRST       32'h3C57_0001
`define WDT_KEY_SECOND      32'h007F_4AD6

`define WDT_PERIOD_0        33'h0_0000_2000
`define WDT_PERIOD_1        33'h0_0008_0000
`define WDT_PERIOD_2        33'h0_0040_0000
`define WDT_PERIOD_3        33'h1_0000_0000

`endif

// File: shared/gtw_pkg.sv
// types shared by the timer and watchdog block
package gtw_pkg;

  typedef enum logic [0:0] {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND
  } key_state_e;

  typedef logic [1:0] timeout_sel_t;

endpackage

// File: rtl/timer_channel.sv
// one up-counting general timer with rollover pulse
`timescale 1ns/1ns
`default_nettype none
`include "gtw_consts.svh"

module timer_channel #(
  parameter int WIDTH = 32
) (
  input  wire logic             clock,      // system clock
  input  wire logic             sys_rst,    // sync reset, high
  input  wire logic             run,        // count enable
  input  wire logic             load,       // software write of count
  input  wire logic [WIDTH-1:0] load_value, // start value
  input  wire logic             irq_enable, // rollover interrupt enable
  output logic      [WIDTH-1:0] count,      // current count
  output logic                  wrap_irq    // one-cycle rollover request
);

  logic [WIDTH-1:0] count_reg;
  logic             at_max;

  assign at_max = (count_reg == {WIDTH{1'b1}});
  assign count  = count_reg;

  // a software load wins over the increment of the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (run) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // no reload after the wrap: software rewrites the count if wanted
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrap_irq <= 1'b0;
    end else begin
      wrap_irq <= run && !load && at_max && irq_enable;
    end
  end

endmodule
`default_nettype wire

// File: rtl/watchdog_counter.sv
// watchdog cycle counter with expiry pulse
`timescale 1ns/1ns
`default_nettype none

module watchdog_counter (
  input  wire logic        clock,    // system clock
  input  wire logic        sys_rst,  // sync reset, high
  input  wire logic        run,      // watchdog enabled
  input  wire logic        service,  // valid key pair seen
  input  wire logic [31:0] last_cnt, // selected period minus one
  output logic             expired   // one-cycle expiry pulse
);

  logic [31:0] cnt_reg;
  logic        hit;

  assign hit = run && !service && (cnt_reg == last_cnt);

  // restart from zero on expiry so that later expiries are seen too
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_reg <= 32'h0000_0000;
    end else if (service || hit) begin
      cnt_reg <= 32'h0000_0000;
    end else if (run) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      expired <= 1'b0;
    end else begin
      expired <= hit;
    end
  end

endmodule
`default_nettype wire

// File: rtl/general_timers_and_watchdog.sv
// three general timers and the watchdog unit behind a simple register port
`timescale 1ns/1ns
`default_nettype none
`include "gtw_consts.svh"

// How it works
// - A running timer counts up from its loaded value to all ones, wraps to zero and keeps going.
// - A wrap with the interrupt enabled raises that timer's interrupt request.
// - A timer control bit of 1 runs the counter, 0 holds it, and it resets to 0.
// - Each count register is 32-bit read-write, zero after reset, written as start, read as current.
// - A 2-bit select picks a watchdog period of 2^13, 2^19, 2^22 or 2^32 cycles and resets to 0.
// - Once enabled the watchdog counts cycles from zero and triggers at the selected limit.
// - After a reset caused by a watchdog expiry the watchdog reset flag is set; software may clear it.
// - With reset-enable set, a watchdog expiry forces a reset of the microcontroller.
// - Reset-enable can be set by software but clearing writes are ignored.
// - The watchdog enable stays set until a reset, ignoring clearing writes.
// - Writing the first and then the second key word back to back clears the watchdog counter.
module general_timers_and_watchdog #(
  parameter int          TIMERS       = 3,
  parameter int          WIDTH        = 32,
  parameter logic [32:0] WDT_PERIOD_0 = `WDT_PERIOD_0,
  parameter logic [32:0] WDT_PERIOD_1 = `WDT_PERIOD_1,
  parameter logic [32:0] WDT_PERIOD_2 = `WDT_PERIOD_2,
  parameter logic [32:0] WDT_PERIOD_3 = `WDT_PERIOD_3
) (
  input  wire logic              clock,         // 50 MHz system clock
  input  wire logic              sys_rst,       // sync reset, high
  input  wire logic              por_rst,       // sync power-on reset, high
  input  wire logic [31:0]       bus_addr,      // register byte address
  input  wire logic [31:0]       bus_wdata,     // write data
  input  wire logic              bus_wr,        // write strobe
  input  wire logic              bus_rd,        // read strobe
  output logic      [31:0]       bus_rdata,     // read data, cycle after strobe
  output logic      [TIMERS-1:0] timer_irq,     // rollover pulses
  output logic                   wdt_reset_req  // one-cycle chip reset request
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [TIMERS-1:0] hit_count;
  logic [TIMERS-1:0] hit_control;
  logic              hit_setup;
  logic              hit_key;
  logic              hit_irq_en;
  logic              bus_access;

  assign bus_access = bus_wr || bus_rd;

  always_comb begin
    hit_setup  = 1'b0;
    hit_key    = 1'b0;
    hit_irq_en = 1'b0;
    if (bus_addr == `ADDR_WDT_SETUP) begin
      hit_setup = 1'b1;
    end else if (bus_addr == `ADDR_WDT_KEY) begin
      hit_key = 1'b1;
    end else if (bus_addr == `ADDR_TIMER_IRQ_EN) begin
      hit_irq_en = 1'b1;
    end
  end

  genvar t;
  generate
    for (t = 0; t < TIMERS; t++) begin : g_dec
      localparam logic [31:0] STEP = 32'(t) * `TIMER_STRIDE;
      assign hit_count[t]   = (bus_addr == `ADDR_GENERAL_TIMER_A_COUNT + STEP);
      assign hit_control[t] = (bus_addr == `ADDR_GENERAL_TIMER_A_CONTROL + STEP);
    end
  endgenerate

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  logic [TIMERS-1:0] run_reg;
  logic [TIMERS-1:0] irq_en_reg;
  logic [WIDTH-1:0]  count_val [TIMERS];
  logic [TIMERS-1:0] wrap_irq;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_en_reg <= '0;
    end else if (bus_wr && hit_irq_en) begin
      irq_en_reg <= bus_wdata[TIMERS-1:0];
    end
  end

  generate
    for (t = 0; t < TIMERS; t++) begin : g_timer
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          run_reg[t] <= 1'b0;
        end else if (bus_wr && hit_control[t]) begin
          run_reg[t] <= bus_wdata[`TIMER_RUN_BIT];
        end
      end

      timer_channel #(
        .WIDTH (WIDTH)
      ) u_timer (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .run        (run_reg[t]),
        .load       (bus_wr && hit_count[t]),
        .load_value (bus_wdata[WIDTH-1:0]),
        .irq_enable (irq_en_reg[t]),
        .count      (count_val[t]),
        .wrap_irq   (wrap_irq[t])
      );
    end
  endgenerate

  // channel pulses already come from flops
  assign timer_irq = wrap_irq;

  // ---------------------------------------------------------------
  // watchdog setup register
  // ---------------------------------------------------------------
  logic                wdt_enable_reg;
  logic                wdt_expiry_reset_enable_reg;
  logic                wdt_flag_reg;
  gtw_pkg::timeout_sel_t wdt_sel_reg;
  logic                setup_wr;

  assign setup_wr = bus_wr && hit_setup;

  // set-only bits: a zero written later has no effect
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdt_enable_reg <= 1'b0;
    end else if (setup_wr && bus_wdata[`WDT_ENABLE_BIT]) begin
      wdt_enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdt_expiry_reset_enable_reg <= 1'b0;
    end else if (setup_wr && bus_wdata[`WDT_EXPIRY_RESET_ENABLE_BIT]) begin
      wdt_expiry_reset_enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdt_sel_reg <= `WDT_SEL_RESET;
    end else if (setup_wr) begin
      wdt_sel_reg <= bus_wdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
    end
  end

  // ---------------------------------------------------------------
  // reset cause: survives sys_rst, cleared by power-on reset or on the first cycle after reset release
  // ---------------------------------------------------------------
  logic cause_reg;
  logic in_rst_reg;
  logic wdt_expired;

  always_ff @(posedge clock) begin
    if (por_rst) begin
      in_rst_reg <= 1'b1;
    end else begin
      in_rst_reg <= sys_rst;
    end
  end

  // held through the reset, dropped on the first cycle after release
  always_ff @(posedge clock) begin
    if (por_rst) begin
      cause_reg <= 1'b0;
    end else if (wdt_expired && wdt_expiry_reset_enable_reg && !sys_rst) begin
      cause_reg <= 1'b1;
    end else if (in_rst_reg && !sys_rst) begin
      cause_reg <= 1'b0;
    end
  end

  // flag is loaded from the cause while reset is held
  always_ff @(posedge clock) begin
    if (por_rst) begin
      wdt_flag_reg <= 1'b0;
    end else if (sys_rst) begin
      wdt_flag_reg <= cause_reg;
    end else if (setup_wr && !bus_wdata[`WDT_FLAG_BIT]) begin
      wdt_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // key sequence
  // ---------------------------------------------------------------
  gtw_pkg::key_state_e key_state_reg;
  logic [31:0]         key_reg;
  logic                key_wr;
  logic                service;

  assign key_wr  = bus_wr && hit_key;
  assign service = (key_state_reg == gtw_pkg::KEY_WAIT_SECOND) && key_wr &&
                   (bus_wdata == `WDT_KEY_SECOND);

  // after the first word, any bus access but a repeated first key word resets the sequencer, so only that may slip between the words
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_state_reg <= gtw_pkg::KEY_WAIT_FIRST;
    end else if (bus_access) begin
      case (key_state_reg)
        gtw_pkg::KEY_WAIT_FIRST: begin
          if (key_wr && bus_wdata == `WDT_KEY_FIRST) begin
            key_state_reg <= gtw_pkg::KEY_WAIT_SECOND;
          end
        end
        gtw_pkg::KEY_WAIT_SECOND: begin
          if (key_wr && bus_wdata == `WDT_KEY_FIRST) begin
            key_state_reg <= gtw_pkg::KEY_WAIT_SECOND;
          end else begin
            key_state_reg <= gtw_pkg::KEY_WAIT_FIRST;
          end
        end
        default: begin
          key_state_reg <= gtw_pkg::KEY_WAIT_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_reg <= `WDT_KEY_RESET;
    end else if (key_wr) begin
      key_reg <= bus_wdata;
    end
  end

  // ---------------------------------------------------------------
  // watchdog counter and reset request
  // ---------------------------------------------------------------
  logic [31:0] last_cnt;

  always_comb begin
    case (wdt_sel_reg)
      2'h0:    last_cnt = 32'(WDT_PERIOD_0 - 33'h0_0000_0001);
      2'h1:    last_cnt = 32'(WDT_PERIOD_1 - 33'h0_0000_0001);
      2'h2:    last_cnt = 32'(WDT_PERIOD_2 - 33'h0_0000_0001);
      default: last_cnt = 32'(WDT_PERIOD_3 - 33'h0_0000_0001);
    endcase
  end

  watchdog_counter u_wdt (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .run      (wdt_enable_reg),
    .service  (service),
    .last_cnt (last_cnt),
    .expired  (wdt_expired)
  );

  // without reset-enable the expiry is silent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= wdt_expired && wdt_expiry_reset_enable_reg;
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < TIMERS; i++) begin
      if (hit_count[i]) begin
        rd_mux = 32'(count_val[i]);
      end
      if (hit_control[i]) begin
        rd_mux[`TIMER_RUN_BIT] = run_reg[i];
      end
    end
    if (hit_setup) begin
      rd_mux[`WDT_ENABLE_BIT]               = wdt_enable_reg;
      rd_mux[`WDT_EXPIRY_RESET_ENABLE_BIT]                = wdt_expiry_reset_enable_reg;
      rd_mux[`WDT_FLAG_BIT]                 = wdt_flag_reg;
      rd_mux[`WDT_SEL_MSB:`WDT_SEL_LSB]     = wdt_sel_reg;
    end else if (hit_key) begin
      rd_mux = key_reg;
    end else if (hit_irq_en) begin
      rd_mux[TIMERS-1:0] = irq_en_reg;
    end
  end

  // unmapped or idle reads give zero; data stands one cycle only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      bus_rdata <= rd_mux;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// File: dv/general_timers_and_watchdog_properties.sv
// port-level assertions for the timers and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "gtw_consts.svh"

module general_timers_and_watchdog_properties #(
  parameter int          TIMERS       = 3,
  parameter int          WIDTH        = 32,
  parameter logic [32:0] WDT_PERIOD_0 = `WDT_PERIOD_0,
  parameter logic [32:0] WDT_PERIOD_1 = `WDT_PERIOD_1,
  parameter logic [32:0] WDT_PERIOD_2 = `WDT_PERIOD_2,
  parameter logic [32:0] WDT_PERIOD_3 = `WDT_PERIOD_3
) (
  input wire logic              clock,         // system clock
  input wire logic              sys_rst,       // sync reset, high
  input wire logic              por_rst,       // power-on reset, high
  input wire logic [31:0]       bus_addr,      // register address
  input wire logic [31:0]       bus_wdata,     // write data
  input wire logic              bus_wr,        // write strobe
  input wire logic              bus_rd,        // read strobe
  input wire logic [31:0]       bus_rdata,     // read data
  input wire logic [TIMERS-1:0] timer_irq,     // rollover pulses
  input wire logic              wdt_reset_req  // chip reset request
);
  logic              rd_setup_q;
  logic              en_q;
  logic              expiry_reset_enable_q;
  logic [TIMERS-1:0] irq_en_q;

  // shadow of the sticky setup bits and the timer interrupt enables, built only from bus traffic
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_setup_q <= 1'b0;
      en_q       <= 1'b0;
      expiry_reset_enable_q    <= 1'b0;
      irq_en_q   <= '0;
    end else begin
      rd_setup_q <= bus_rd && bus_addr == `ADDR_WDT_SETUP;
      if (bus_wr && bus_addr == `ADDR_WDT_SETUP) begin
        en_q    <= en_q | bus_wdata[0];
        expiry_reset_enable_q <= expiry_reset_enable_q | bus_wdata[1];
      end
      if (bus_wr && bus_addr == `ADDR_TIMER_IRQ_EN) begin
        irq_en_q <= bus_wdata[TIMERS-1:0];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_rdata_after_read: assert property (bus_rdata != 32'h0 |-> $past(bus_rd))
    else $error("read data outside the answer cycle");
  chk_enable_sticky: assert property (rd_setup_q |-> bus_rdata[0] == en_q)
    else $error("watchdog enable not sticky");
  chk_expiry_reset_enable_sticky: assert property (rd_setup_q |-> bus_rdata[1] == expiry_reset_enable_q)
    else $error("reset enable not sticky");
  chk_key_readback: assert property ((bus_wr && bus_addr == `ADDR_WDT_KEY) ##1 !bus_wr
    ##1 (bus_rd && bus_addr == `ADDR_WDT_KEY) |=> bus_rdata == $past(bus_wdata, 3))
    else $error("key register readback wrong");
  chk_control_readback: assert property ((bus_wr && bus_addr == `ADDR_GENERAL_TIMER_A_CONTROL) ##1 !bus_wr
    ##1 (bus_rd && bus_addr == `ADDR_GENERAL_TIMER_A_CONTROL) |=> bus_rdata == ($past(bus_wdata, 3) & 32'h1))
    else $error("control readback wrong");
  chk_irq_needs_enable: assert property (timer_irq != '0 |-> (timer_irq & ~irq_en_q) == '0)
    else $error("masked timer raised a request");
  chk_irq_one_cycle: assert property (timer_irq != '0 |-> (timer_irq & $past(timer_irq)) == '0)
    else $error("rollover request longer than one cycle");
  chk_req_needs_expiry_reset_enable: assert property (wdt_reset_req |-> expiry_reset_enable_q && en_q)
    else $error("reset request without reset enable");
  chk_req_restarts: assert property (wdt_reset_req |=> !wdt_reset_req [*8])
    else $error("watchdog counter did not restart");
  chk_quiet_after_reset: assert property ($fell(sys_rst) |-> (timer_irq == '0 && !wdt_reset_req) [*3])
    else $error("event output active after reset");
endmodule

bind general_timers_and_watchdog general_timers_and_watchdog_properties #(
  .TIMERS(TIMERS), .WIDTH(WIDTH), .WDT_PERIOD_0(WDT_PERIOD_0), .WDT_PERIOD_1(WDT_PERIOD_1),
  .WDT_PERIOD_2(WDT_PERIOD_2), .WDT_PERIOD_3(WDT_PERIOD_3)
) i_general_timers_and_watchdog_properties (
  .clock(clock), .sys_rst(sys_rst), .por_rst(por_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_irq(timer_irq),
  .wdt_reset_req(wdt_reset_req)
);

`default_nettype wire

// File: dv/general_timers_and_watchdog_tb.sv
// self-checking bench for the timers and watchdog block
`timescale 1ns/1ns
`default_nettype none
`include "gtw_consts.svh"

module general_timers_and_watchdog_tb;
  logic        clock         = 1'b0;
  logic        sys_rst       = 1'b1;
  logic        por_rst       = 1'b1;
  logic [31:0] bus_addr      = 32'h0;
  logic [31:0] bus_wdata     = 32'h0;
  logic        bus_wr        = 1'b0;
  logic        bus_rd        = 1'b0;
  logic [31:0] bus_rdata;
  logic [2:0]  timer_irq;
  logic        wdt_reset_req;
  int          miscompares   = 0;
  int          cmp_count     = 0;
  int          req_seen      = 0;
  int          n;
  int          d;
  time         t0;
  logic [31:0] a;
  logic [31:0] rv;
  // shortened periods keep the run small; expectations follow these values
  int          periods [4]   = '{16, 32, 64, 128};

  always #10 clock = ~clock;

  always @(posedge clock) begin
    if (wdt_reset_req === 1'b1) begin
      req_seen <= req_seen + 1;
    end
  end

  general_timers_and_watchdog #(
    .WDT_PERIOD_0(33'h0_0000_0010), .WDT_PERIOD_1(33'h0_0000_0020),
    .WDT_PERIOD_2(33'h0_0000_0040), .WDT_PERIOD_3(33'h0_0000_0080)
  ) i_general_timers_and_watchdog (
    .clock(clock), .sys_rst(sys_rst), .por_rst(por_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_irq(timer_irq),
    .wdt_reset_req(wdt_reset_req)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge clock);
    bus_addr  <= ad;
    bus_wdata <= dt;
    bus_wr    <= 1'b1;
    @(posedge clock);
    bus_wr    <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [31:0] ad, output logic [31:0] dt);
    @(posedge clock);
    bus_addr <= ad;
    bus_rd   <= 1'b1;
    @(posedge clock);
    bus_rd   <= 1'b0;
    #1 dt = bus_rdata;
  endtask

  task automatic rdc(input logic [31:0] ad, input logic [31:0] exp);
    logic [31:0] dt;
    rd(ad, dt);
    check(dt, exp);
  endtask

  task automatic rst_dut(input logic por);
    @(posedge clock);
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
  endtask

  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    summarize;
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdc(32'h5002_0000 + 32'(4 * i), 32'h0);
    rdc(`ADDR_TIMER_IRQ_EN, 32'h0);
    wr(`ADDR_TIMER_IRQ_EN, 32'h7);
    for (int i = 0; i < 3; i++) begin
      a = `ADDR_GENERAL_TIMER_A_COUNT + 32'(8 * i);
      wr(a, 32'h1234_5678);
      rdc(a, 32'h1234_5678);
      wr(a, 32'hFFFF_FFF0);
      wr(a + 32'h4, 32'hFFFF_FFFF);
      rdc(a + 32'h4, 32'h1);
      n = 0;
      while (timer_irq[i] !== 1'b1 && n < 40) begin
        @(posedge clock);
        #1 n++;
      end
      check(32'(n < 40), 32'h1);
      rd(a, rv);
      check(32'(rv < 32'h10), 32'h1);
      wr(a + 32'h4, 32'h0);
      rd(a, rv);
      rdc(a, rv);
    end
    wr(`ADDR_TIMER_IRQ_EN, 32'h6);
    wr(`ADDR_GENERAL_TIMER_A_COUNT, 32'hFFFF_FFF0);
    wr(`ADDR_GENERAL_TIMER_A_CONTROL, 32'h1);
    n = 0;
    repeat (40) begin
      @(posedge clock);
      #1 if (timer_irq[0] === 1'b1) n++;
    end
    check(32'(n), 32'h0);
    rd(`ADDR_GENERAL_TIMER_A_COUNT, rv);
    check(32'(rv < 32'h40), 32'h1);
    for (int k = 0; k < 4; k++) begin
      rst_dut(1'b1);
      wr(`ADDR_WDT_SETUP, 32'(k << 3) | 32'h3);
      t0 = $time;
      wr(`ADDR_WDT_SETUP, 32'(k << 3));
      rdc(`ADDR_WDT_SETUP, 32'(k << 3) | 32'h3);
      n = 0;
      while (wdt_reset_req !== 1'b1 && n < 300) begin
        @(posedge clock);
        #1 n++;
      end
      d = int'(($time - t0) / 20);
      check(32'(d >= periods[k] && d <= periods[k] + 3), 32'h1);
      rst_dut(1'b0);
      rdc(`ADDR_WDT_SETUP, 32'h4);
      wr(`ADDR_WDT_SETUP, 32'h0);
      rdc(`ADDR_WDT_SETUP, 32'h0);
    end
    // pattern 0 services properly; 1 and 2 break the pair and must let it expire
    rst_dut(1'b1);
    wr(`ADDR_WDT_SETUP, 32'hB);
    for (int p = 0; p < 3; p++) begin
      n = req_seen;
      repeat (6) begin
        wr(`ADDR_WDT_KEY, `WDT_KEY_FIRST);
        if (p == 1) wr(`ADDR_WDT_KEY, 32'h3C57_0002);
        if (p == 2) rd(`ADDR_GENERAL_TIMER_A_COUNT, rv);
        wr(`ADDR_WDT_KEY, `WDT_KEY_SECOND);
        repeat (8) @(posedge clock);
      end
      #1 check(32'(req_seen != n), 32'(p != 0));
    end
    wr(`ADDR_WDT_KEY, 32'h5A5A_A5A5);
    rdc(`ADDR_WDT_KEY, 32'h5A5A_A5A5);
    rst_dut(1'b1);
    wr(`ADDR_WDT_SETUP, 32'h1);
    n = req_seen;
    repeat (60) @(posedge clock);
    #1 check(32'(req_seen - n), 32'h0);
    summarize;
  end
endmodule

`default_nettype wire
